// file: self_program_flash_defines.svh
// Register offsets, field positions, reset values and timing counts of the
// self-programming flash controller.
// Assumes it is included by the package-aware design files.
`ifndef SELF_PROGRAM_FLASH_DEFINES_SVH
`define SELF_PROGRAM_FLASH_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------------------
`define SPF_OFF_ADDR_LOW 8'h00
`define SPF_OFF_ADDR_HIGH 8'h04
`define SPF_OFF_DATA_LOW 8'h08
`define SPF_OFF_DATA_HIGH 8'h0C
`define SPF_OFF_CONTROL 8'h10
`define SPF_OFF_UNLOCK 8'h14
`define SPF_OFF_CONFIG 8'h18

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SPF_CTL_RD 0
`define SPF_CTL_WR 1
`define SPF_CTL_WRITE_ENABLE_BIT 2
`define SPF_CTL_WRITE_ERROR_FLAG 3
`define SPF_CTL_ERASE 4
`define SPF_CTL_LATCH_ONLY 5
`define SPF_CTL_CONFIG_SPACE_SELECT 6

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define SPF_KEY_FIRST 8'h55
`define SPF_KEY_SECOND 8'hAA
`define SPF_BLANK_WORD 14'h3FFF
`define SPF_WRT_OFF 2'h3
`define SPF_WRT_LOW 2'h2
`define SPF_WRT_HALF 2'h1
`define SPF_WRT_LIMIT_LOW 15'h0200
`define SPF_WRT_LIMIT_HALF 15'h1000
`define SPF_SYNC_SETTLE 2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPF_OP_TIME_NS 2000000
`define SPF_PCLK_PERIOD_NS 10
`define SPF_OP_CYCLES (`SPF_OP_TIME_NS / `SPF_PCLK_PERIOD_NS)

`endif

// file: self_program_flash_pkg.sv
// Types shared by the self-programming flash controller and its helpers.
// Assumes nothing of its surroundings.
`default_nettype none

package self_program_flash_pkg;

  typedef enum logic [9:0] {
    ST_IDLE    = 10'h001,
    ST_RD_SKIP = 10'h002,
    ST_RD_ACC  = 10'h004,
    ST_RD_CAP  = 10'h008,
    ST_NOP1    = 10'h010,
    ST_NOP2    = 10'h020,
    ST_XFER    = 10'h040,
    ST_WAIT    = 10'h080,
    ST_PX_ACC  = 10'h100,
    ST_PX_CAP  = 10'h200
  } seq_state_e;

  typedef enum logic [2:0] {
    UK_IDLE      = 3'h1,
    UK_GOT_FIRST = 3'h2,
    UK_ARMED     = 3'h4
  } unlock_state_e;

  typedef enum logic [1:0] {
    PGM_READ  = 2'h0,
    PGM_WRITE = 2'h1,
    PGM_BULK  = 2'h2
  } pgm_op_e;

  typedef enum logic [1:0] {
    OPK_ERASE   = 2'h0,
    OPK_PROGRAM = 2'h1,
    OPK_BULK    = 2'h2
  } op_kind_e;

endpackage

`default_nettype wire

// file: flash_unlock_detect.sv
// Unlock key sequence detector.
// Assumes one completed APB access per acc_done pulse, on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "self_program_flash_defines.svh"

module flash_unlock_detect
  import self_program_flash_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic acc_done,
  input wire logic acc_write,
  input wire logic acc_key,
  input wire logic acc_ctrl,
  input wire logic [7:0] acc_wdata,
  output logic unlock_ok
);

  unlock_state_e state_q;
  unlock_state_e state_d;

  wire logic key_first = acc_done & acc_write & acc_key & (acc_wdata == `SPF_KEY_FIRST);
  wire logic key_second = acc_done & acc_write & acc_key & (acc_wdata == `SPF_KEY_SECOND);
  wire logic strobe_set = acc_done & acc_write & acc_ctrl & acc_wdata[`SPF_CTL_WR];

  // Any access other than the expected next one drops the sequence.
  assign unlock_ok = (state_q == UK_ARMED) & strobe_set;

  always_comb begin
    state_d = state_q;
    case (state_q)
      UK_IDLE: begin
        if (key_first) state_d = UK_GOT_FIRST;
      end
      UK_GOT_FIRST: begin
        if (acc_done) state_d = key_second ? UK_ARMED : (key_first ? UK_GOT_FIRST : UK_IDLE);
      end
      UK_ARMED: begin
        if (acc_done) state_d = key_first ? UK_GOT_FIRST : UK_IDLE;
      end
      default: begin
        state_d = UK_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= UK_IDLE;
    else state_q <= state_d;
  end

endmodule

`default_nettype wire

// file: flash_write_latches.sv
// Row write latch buffer, filled one word at a time and cleared to blank.
// Assumes load and clear requests come from the sequencer on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "self_program_flash_defines.svh"

module flash_write_latches #(
  parameter int WORDS = 32,
  parameter int WIDTH = 14,
  parameter int IDX_W = 5,
  parameter logic [WIDTH-1:0] BLANK = `SPF_BLANK_WORD
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load_en,
  input wire logic [IDX_W-1:0] load_idx,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic clear_all,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);

  if (WORDS != (1 << IDX_W)) begin : g_chk
    $error("flash_write_latches: WORDS must equal 2**IDX_W");
  end

  logic [WIDTH-1:0] word_q [WORDS];

  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) word_q[i] <= BLANK;
      else if (clear_all) word_q[i] <= BLANK;
      else if (load_en && load_idx == IDX_W'(i)) word_q[i] <= load_data;
    end
  end

  assign rd_data = word_q[rd_idx];

endmodule

`default_nettype wire

// file: self_program_flash_ctrl.sv
// Self-programming flash controller: APB register file, read timing, unlock
// gate, row erase and row program sequencing, and external programmer port.
// Assumes the flash array and programmer logic run on pclk; configuration
// bits and the array abort status arrive from outside and are synchronised.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "self_program_flash_defines.svh"

// Functional notes
// - Data pair holds one 14-bit word for reads and writes.
// - Address pair forms a 15-bit word address, high and low byte.
// - Address reaches any word of a 32K-word space.
// - Erase and program durations come from an internal timer.
// - Code protect refuses programmer reads and writes; self-write still works.
// - Only a programmer bulk erase lifts code protection.
// - Write-protect field blocks self erase/write of its region only.
// - Read and write strobes are set-only; hardware clears them when done.
// - Write or erase only with write enable set; enable clear at reset.
// - A reset during a write sets the write error flag afterwards.
// - Unlock key register reads as zero.
// - Rows of 32 words; row is the erase unit; 32 write latches.
// - Latches are filled only through the data pair.
// - Unprogrammed words may be programmed without a prior erase.
// - Read uses the second cycle for access; data appears next cycle.
// - Data pair keeps its value until a read or a software write.
// - Erase, latch load and program start only after an unbroken unlock.
// - Write strobe forces two no-ops; erase or program stalls about 2 ms.
// - Latch load forces two no-ops and no stall.
// - Every erase or program completion resets latches to blank.
// - Latch-only set loads one latch; clear with erase clear programs all latches, clear with erase set erases the row.
// - Upper address bits pick the row, low bits the latch; no row crossing.
module self_program_flash_ctrl
  import self_program_flash_pkg::*;
#(
  parameter int LATCH_WORDS = 32,
  parameter int OP_CYCLES = `SPF_OP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic core_nop,
  output logic core_stall,
  output logic [14:0] arr_addr,
  output logic arr_cfg_space,
  output logic arr_read,
  input wire logic [13:0] arr_rdata,
  output logic arr_word_wr,
  output logic [13:0] arr_wdata,
  output logic arr_erase_row,
  output logic arr_program_row,
  output logic arr_bulk_erase,
  input wire logic arr_abort_seen,
  input wire logic code_protect_bit,
  input wire logic [1:0] write_protect_field,
  input wire logic pgm_req,
  input wire logic [1:0] pgm_op,
  input wire logic [14:0] pgm_addr,
  input wire logic [13:0] pgm_wdata,
  output logic pgm_ack,
  output logic pgm_refused,
  output logic [13:0] pgm_rdata
);

  localparam int IDX_W = $clog2(LATCH_WORDS);
  localparam int CNT_W = $clog2(OP_CYCLES + 1);

  if (OP_CYCLES < 2 || LATCH_WORDS < 2 || LATCH_WORDS > 64 || (1 << IDX_W) != LATCH_WORDS) begin : g_chk
    $error("self_program_flash_ctrl: unsupported OP_CYCLES or LATCH_WORDS");
  end

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Write protection guards the low end of the array, where boot code lives.
  function automatic logic wp_blocks(input logic [1:0] field, input logic [14:0] a);
    case (field)
      `SPF_WRT_OFF: wp_blocks = 1'b0;
      `SPF_WRT_LOW: wp_blocks = (a < `SPF_WRT_LIMIT_LOW);
      `SPF_WRT_HALF: wp_blocks = (a < `SPF_WRT_LIMIT_HALF);
      default: wp_blocks = 1'b1;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  seq_state_e state_q, state_d;
  op_kind_e op_kind_q, op_kind_d;
  logic [CNT_W-1:0] cnt_q;
  logic [IDX_W-1:0] xfer_q;
  logic [14:0] addr_q;
  logic [13:0] data_q;
  logic rd_q, wr_q, write_enable_bit_q, werr_q, erase_q, lonly_q, config_space_select_q;
  logic [3:0] sync1_q, sync2_q;
  logic [1:0] settle_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, core_nop_q, core_stall_q;
  logic [14:0] arr_addr_q;
  logic arr_cfg_q, arr_read_q, arr_word_wr_q, arr_erase_q, arr_program_q, arr_bulk_q;
  logic [13:0] arr_wdata_q, pgm_rdata_q;
  logic pgm_ack_q, pgm_refused_q;
  logic unlock_ok;
  logic [13:0] latch_rd;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  wire logic acc_done = psel & penable & pready_q;
  wire logic acc_first = psel & penable & ~pready_q;
  wire logic wr_take = acc_done & pwrite;
  wire logic sel_alow = hit(paddr, `SPF_OFF_ADDR_LOW);
  wire logic sel_ahigh = hit(paddr, `SPF_OFF_ADDR_HIGH);
  wire logic sel_dlow = hit(paddr, `SPF_OFF_DATA_LOW);
  wire logic sel_dhigh = hit(paddr, `SPF_OFF_DATA_HIGH);
  wire logic sel_ctl = hit(paddr, `SPF_OFF_CONTROL);
  wire logic sel_key = hit(paddr, `SPF_OFF_UNLOCK);
  wire logic sel_cfg = hit(paddr, `SPF_OFF_CONFIG);
  wire logic mapped = sel_alow | sel_ahigh | sel_dlow | sel_dhigh | sel_ctl | sel_key | sel_cfg;
  wire logic ctl_wr = wr_take & sel_ctl;

  // The config bits are static fuses, but they still pass two flops.
  wire logic cp_off_s = sync2_q[0];
  wire logic [1:0] wrt_s = sync2_q[2:1];
  wire logic abort_s = sync2_q[3];

  wire logic is_idle = (state_q == ST_IDLE);
  wire logic row_protected = wp_blocks(wrt_s, addr_q);
  wire logic [6:0] ctl_val = {config_space_select_q, lonly_q, erase_q, werr_q, write_enable_bit_q, wr_q, rd_q};
  wire logic [31:0] rd_mux = sel_alow ? {24'h00_0000, addr_q[7:0]} :
                             sel_ahigh ? {25'h000_0000, addr_q[14:8]} :
                             sel_dlow ? {24'h00_0000, data_q[7:0]} :
                             sel_dhigh ? {26'h000_0000, data_q[13:8]} :
                             sel_ctl ? {25'h000_0000, ctl_val} :
                             sel_cfg ? {28'h000_0000, ~is_idle, wrt_s, cp_off_s} :
                             32'h0000_0000;

  // --------------------------------------------------------------------------
  // Sequencer control terms
  // --------------------------------------------------------------------------
  wire logic free = is_idle & ~rd_q & ~wr_q;
  wire logic wr_start = unlock_ok & write_enable_bit_q & ~row_protected & free;
  wire logic rd_start = ctl_wr & pwdata[`SPF_CTL_RD] & free & ~wr_start;
  wire logic pgm_bulk = (pgm_op == PGM_BULK);
  wire logic pgm_take = pgm_req & free & (cp_off_s | pgm_bulk);
  wire logic wait_done = (state_q == ST_WAIT) & (cnt_q == CNT_W'(1));
  wire logic nop2_load = (state_q == ST_NOP2) & lonly_q;
  wire logic catch_err = (settle_q == `SPF_SYNC_SETTLE) & abort_s;
  wire logic werr_clr = ctl_wr & ~pwdata[`SPF_CTL_WRITE_ERROR_FLAG];
  wire logic [14:0] xfer_addr = {addr_q[14:IDX_W], xfer_q};

  flash_unlock_detect u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .acc_done(acc_done),
    .acc_write(pwrite),
    .acc_key(sel_key),
    .acc_ctrl(sel_ctl),
    .acc_wdata(pwdata[7:0]),
    .unlock_ok(unlock_ok)
  );

  flash_write_latches #(
    .WORDS(LATCH_WORDS),
    .WIDTH(14),
    .IDX_W(IDX_W)
  ) u_latches (
    .pclk(pclk),
    .presetn(presetn),
    .load_en(nop2_load),
    .load_idx(addr_q[IDX_W-1:0]),
    .load_data(data_q),
    .clear_all(wait_done),
    .rd_idx(xfer_q),
    .rd_data(latch_rd)
  );

  always_comb begin
    state_d = state_q;
    op_kind_d = op_kind_q;
    case (state_q)
      ST_IDLE: begin
        if (rd_q) state_d = ST_RD_SKIP;
        else if (wr_q) state_d = ST_NOP1;
        else if (pgm_take && pgm_op == PGM_READ) state_d = ST_PX_ACC;
        else if (pgm_take && pgm_bulk) begin
          state_d = ST_WAIT;
          op_kind_d = OPK_BULK;
        end
      end
      ST_RD_SKIP: begin
        state_d = ST_RD_ACC;
      end
      ST_RD_ACC: begin
        state_d = ST_RD_CAP;
      end
      ST_NOP1: begin
        state_d = ST_NOP2;
      end
      ST_NOP2: begin
        if (lonly_q) state_d = ST_IDLE;
        else if (erase_q) begin
          state_d = ST_WAIT;
          op_kind_d = OPK_ERASE;
        end else begin
          state_d = ST_XFER;
          op_kind_d = OPK_PROGRAM;
        end
      end
      ST_XFER: begin
        if (xfer_q == IDX_W'(LATCH_WORDS - 1)) state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (wait_done) state_d = ST_IDLE;
      end
      ST_PX_ACC: begin
        state_d = ST_PX_CAP;
      end
      ST_RD_CAP, ST_PX_CAP: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      op_kind_q <= OPK_ERASE;
      cnt_q <= '0;
      xfer_q <= '0;
    end else begin
      state_q <= state_d;
      op_kind_q <= op_kind_d;
      if (state_d == ST_WAIT && state_q != ST_WAIT) cnt_q <= CNT_W'(OP_CYCLES);
      else if (state_q == ST_WAIT) cnt_q <= cnt_q - CNT_W'(1);
      xfer_q <= (state_q == ST_XFER) ? xfer_q + IDX_W'(1) : '0;
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      data_q <= '0;
      {config_space_select_q, lonly_q, erase_q, write_enable_bit_q} <= '0;
    end else begin
      if (wr_take && sel_alow) addr_q[7:0] <= pwdata[7:0];
      if (wr_take && sel_ahigh) addr_q[14:8] <= pwdata[6:0];
      if (state_q == ST_RD_CAP) data_q <= arr_rdata;
      else if (wr_take && sel_dlow) data_q[7:0] <= pwdata[7:0];
      else if (wr_take && sel_dhigh) data_q[13:8] <= pwdata[5:0];
      if (ctl_wr) begin
        config_space_select_q <= pwdata[`SPF_CTL_CONFIG_SPACE_SELECT];
        lonly_q <= pwdata[`SPF_CTL_LATCH_ONLY];
        erase_q <= pwdata[`SPF_CTL_ERASE];
        write_enable_bit_q <= pwdata[`SPF_CTL_WRITE_ENABLE_BIT];
      end
    end
  end

  // Strobes ignore written zeros; only completion clears them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      werr_q <= 1'b0;
      settle_q <= '0;
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      rd_q <= rd_start | (rd_q & (state_q != ST_RD_CAP));
      wr_q <= wr_start | (wr_q & ~wait_done & ~nop2_load);
      werr_q <= catch_err | (werr_q & ~werr_clr);
      settle_q <= (settle_q == 2'h3) ? settle_q : settle_q + 2'h1;
      sync1_q <= {arr_abort_seen, write_protect_field, code_protect_bit};
      sync2_q <= sync1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      core_nop_q <= 1'b0;
      core_stall_q <= 1'b0;
      arr_addr_q <= '0;
      {arr_cfg_q, arr_read_q, arr_word_wr_q, arr_erase_q, arr_program_q, arr_bulk_q} <= '0;
      arr_wdata_q <= '0;
      pgm_rdata_q <= '0;
      pgm_ack_q <= 1'b0;
      pgm_refused_q <= 1'b0;
    end else begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~mapped;
      if (acc_first && !pwrite) prdata_q <= rd_mux;
      core_nop_q <= (state_d == ST_NOP1) | (state_d == ST_NOP2) | (state_d == ST_RD_ACC);
      core_stall_q <= (state_d == ST_XFER) | (state_d == ST_WAIT);
      arr_cfg_q <= config_space_select_q;
      arr_read_q <= (state_d == ST_RD_ACC) | (state_d == ST_PX_ACC);
      arr_addr_q <= (state_q == ST_XFER) ? xfer_addr : (pgm_take ? pgm_addr : addr_q);
      arr_word_wr_q <= (state_q == ST_XFER) | (pgm_take & (pgm_op == PGM_WRITE));
      arr_wdata_q <= (state_q == ST_XFER) ? latch_rd : pgm_wdata;
      arr_erase_q <= (state_d == ST_WAIT) & (op_kind_d == OPK_ERASE);
      arr_program_q <= (state_d == ST_WAIT) & (op_kind_d == OPK_PROGRAM);
      arr_bulk_q <= (state_d == ST_WAIT) & (op_kind_d == OPK_BULK);
      if (state_q == ST_PX_CAP) pgm_rdata_q <= arr_rdata;
      pgm_ack_q <= (pgm_take & (pgm_op == PGM_WRITE)) | (state_q == ST_PX_CAP) |
                   (wait_done & (op_kind_q == OPK_BULK));
      pgm_refused_q <= pgm_req & ~pgm_take;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign core_nop = core_nop_q;
  assign core_stall = core_stall_q;
  assign arr_addr = arr_addr_q;
  assign arr_cfg_space = arr_cfg_q;
  assign arr_read = arr_read_q;
  assign arr_word_wr = arr_word_wr_q;
  assign arr_wdata = arr_wdata_q;
  assign arr_erase_row = arr_erase_q;
  assign arr_program_row = arr_program_q;
  assign arr_bulk_erase = arr_bulk_q;
  assign pgm_ack = pgm_ack_q;
  assign pgm_refused = pgm_refused_q;
  assign pgm_rdata = pgm_rdata_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  int stall_len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stall_len_q <= 0;
    else stall_len_q <= core_stall_q ? stall_len_q + 1 : 0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_key_reads_zero: assert property (acc_done && !pwrite && sel_key |-> prdata_q == 32'h0000_0000)
    else $error("unlock key register read not zero");
  a_read_timing: assert property ($rose(rd_q) |-> ##2 (arr_read_q && core_nop_q) ##2 (!rd_q && data_q == $past(arr_rdata)))
    else $error("read access or data timing wrong");
  a_strobe_set_only: assert property (rd_q && state_q != ST_RD_CAP |=> rd_q)
    else $error("read strobe cleared before completion");
  a_write_gated: assert property ($rose(wr_q) |-> $past(unlock_ok) && $past(write_enable_bit_q))
    else $error("write strobe set without unlock and enable");
  a_forced_nops: assert property ($rose(wr_q) |-> ##1 core_nop_q [*2] ##1 !core_nop_q)
    else $error("two forced no-op cycles missing");
  a_load_no_stall: assert property ($rose(wr_q) && lonly_q |-> (!core_stall_q) [*4] ##0 !wr_q)
    else $error("latch load stalled or did not finish");
  a_erase_timed: assert property ($fell(core_stall_q) && op_kind_q == OPK_ERASE |-> stall_len_q == OP_CYCLES)
    else $error("erase stall length wrong");
  a_latch_blank: assert property (wait_done |=> latch_rd == `SPF_BLANK_WORD)
    else $error("latches not blank after completion");
  a_protect_blocks: assert property (unlock_ok && row_protected && !wr_q |=> !wr_q)
    else $error("write strobe set on protected region");
  a_cp_refuses: assert property (pgm_req && !cp_off_s && pgm_op != PGM_BULK |=> pgm_refused_q && !pgm_ack_q)
    else $error("programmer access not refused under code protect");
  a_werr_caught: assert property (catch_err |=> werr_q)
    else $error("write error flag not set after aborted write");

  c_read_done: cover property (state_q == ST_RD_CAP);
  c_erase_done: cover property (wait_done && op_kind_q == OPK_ERASE);
  c_program_done: cover property (wait_done && op_kind_q == OPK_PROGRAM);
  c_latch_load: cover property (nop2_load);

endmodule

`default_nettype wire

// file: flash_array_model.sv
// Flash array model that stands on the controller's array port.
// Assumes the controller's array strobes on pclk.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  input wire logic pclk,
  input wire logic [14:0] arr_addr,
  input wire logic arr_read,
  input wire logic arr_word_wr,
  input wire logic [13:0] arr_wdata,
  input wire logic arr_erase_row,
  output logic [13:0] arr_rdata
);
  logic [13:0] mem [64];
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 14'h3FFF ^ 14'(i);
    arr_rdata = '0;
  end
  // Outside a read the data lines toggle, so a late capture cannot pass.
  always @(posedge pclk) begin
    arr_rdata <= arr_read ? mem[arr_addr[5:0]] : ~arr_rdata;
    if (arr_word_wr) mem[arr_addr[5:0]] <= mem[arr_addr[5:0]] & arr_wdata;
    if (arr_erase_row) for (int i = 0; i < 32; i++) mem[{arr_addr[5], 5'(i)}] <= 14'h3FFF;
  end
endmodule
`default_nettype wire

// file: test_self_program_flash_ctrl.sv
// Self-checking bench: APB master, table of register cases, flash scenarios.
// Assumes flash_array_model on the array port and OP_CYCLES set to 20.
`timescale 1ns/1ps
`default_nettype none
module test_self_program_flash_ctrl;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, perr, core_nop, core_stall, arr_read, arr_word_wr, arr_erase_row;
  logic [14:0] arr_addr;
  logic [13:0] arr_rdata, arr_wdata;
  int errors = 0, n_compared = 0, k, s, c;
  logic abort_in = 0;
  logic [1:0] wp_field = 2'h3;
  logic [71:0] rows [6] = '{{8'h00, 32'h5, 32'h5}, {8'h04, 32'hFF, 32'h7F}, {8'h08, 32'h23, 32'h23},
    {8'h0C, 32'hC1, 32'h1}, {8'h14, 32'h55, 32'h0}, {8'h18, 32'hF, 32'h7}};
  always #5 pclk = ~pclk;
  self_program_flash_ctrl #(.OP_CYCLES(20)) i_self_program_flash_ctrl (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_nop, .core_stall, .arr_addr,
    .arr_cfg_space(), .arr_read, .arr_rdata, .arr_word_wr, .arr_wdata, .arr_erase_row,
    .arr_program_row(), .arr_bulk_erase(), .arr_abort_seen(abort_in), .code_protect_bit(1'b1),
    .write_protect_field(wp_field), .pgm_req(1'b0), .pgm_op(2'h0), .pgm_addr(15'h0), .pgm_wdata(14'h0),
    .pgm_ack(), .pgm_refused(), .pgm_rdata());
  flash_array_model i_flash_array_model (.pclk, .arr_addr, .arr_read, .arr_word_wr, .arr_wdata,
    .arr_erase_row, .arr_rdata);
  task automatic print_verdict;
    $display("errors %0d, compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1 && k < 20);
    if (pready !== 1) begin
      errors++;
      print_verdict();
    end
    r = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic count_stall(input int n);
    s = 0;
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      s += int'(core_stall === 1);
      c += int'(core_nop === 1);
    end
  endtask
  task automatic unlock(input logic [31:0] ctl);
    apb(1, 8'h14, 32'h55);
    apb(1, 8'h14, 32'hAA);
    apb(1, 8'h10, ctl);
  endtask
  task automatic read_word(input logic [7:0] a, input logic [13:0] e);
    apb(1, 8'h00, {24'h0, a});
    apb(1, 8'h04, 32'h0);
    apb(1, 8'h10, 32'h1);
    count_stall(6);
    chk(c, 1);
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h0);
    apb(0, 8'h08, 32'h0);
    chk(r, {24'h0, e[7:0]});
    apb(0, 8'h0C, 32'h0);
    chk(r, {26'h0, e[13:8]});
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h0);
    read_word(8'h03, 14'h3FFC);
    foreach (rows[i]) begin
      apb(1, rows[i][71:64], rows[i][63:32]);
      apb(0, rows[i][71:64], 32'h0);
      chk(r, rows[i][31:0]);
    end
    apb(0, 8'h3C, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1, 8'h04, 32'h0);
    // An access between the keys must leave the strobe unset.
    apb(1, 8'h10, 32'h24);
    apb(1, 8'h14, 32'h55);
    apb(0, 8'h00, 32'h0);
    apb(1, 8'h14, 32'hAA);
    apb(1, 8'h10, 32'h26);
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h24);
    apb(1, 8'h10, 32'h20);
    unlock(32'h22);
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h20);
    // Address 5 lies in the low protected region, so the strobe must stay clear.
    wp_field <= 2'h2;
    apb(1, 8'h10, 32'h24);
    unlock(32'h26);
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h24);
    wp_field <= 2'h3;
    apb(1, 8'h10, 32'h24);
    unlock(32'h26);
    count_stall(10);
    chk(s, 0);
    chk(c, 2);
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h24);
    unlock(32'h06);
    count_stall(80);
    chk(s, 52);
    chk(c, 2);
    read_word(8'h05, 14'h0122);
    read_word(8'h06, 14'h3FF9);
    apb(1, 8'h10, 32'h14);
    unlock(32'h16);
    count_stall(40);
    chk(s, 20);
    read_word(8'h05, 14'h3FFF);
    // A reset in mid-run while the array reports a cut write.
    apb(1, 8'h10, 32'h4);
    abort_in <= 1;
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h8);
    apb(1, 8'h10, 32'h0);
    apb(0, 8'h10, 32'h0);
    chk(r, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
